// File: design/cod_pkg.sv
package cod_pkg;

  localparam int COD_NCH = 3;
  localparam int COD_AW = 10;

  // register offsets, per channel: counts, divider control, output control
  localparam logic [9:0] COD_CH1_COUNTS = 10'h193;
  localparam logic [9:0] COD_CH1_DCTL = 10'h194;
  localparam logic [9:0] COD_CH1_OCTL = 10'h195;
  localparam logic [9:0] COD_CH2_COUNTS = 10'h196;
  localparam logic [9:0] COD_CH2_DCTL = 10'h197;
  localparam logic [9:0] COD_CH2_OCTL = 10'h198;
  localparam logic [9:0] COD_CH3_COUNTS = 10'h199;
  localparam logic [9:0] COD_CH3_DCTL = 10'h19A;
  localparam logic [9:0] COD_CH3_OCTL = 10'h19B;

  // count register fields
  localparam int COD_LOW_HI = 7;
  localparam int COD_LOW_LO = 4;
  localparam int COD_HIGH_HI = 3;
  localparam int COD_HIGH_LO = 0;

  // divider control fields
  localparam int COD_BYPASS_BIT = 7;
  localparam int COD_IGNSYNC_BIT = 6;
  localparam int COD_FORCE_BIT = 5;
  localparam int COD_START_BIT = 4;
  localparam int COD_PHASE_HI = 3;
  localparam int COD_PHASE_LO = 0;

  // output control fields
  localparam int COD_PD_BIT = 2;
  localparam int COD_DIRECT_BIT = 1;
  localparam int COD_DCCDIS_BIT = 0;
  localparam int COD_OCTL_W = 3;

  // input-select codes for direct routing
  localparam logic [1:0] COD_SRC_OSC = 2'h2;
  localparam logic [1:0] COD_SRC_EXT = 2'h0;

  // reset values
  localparam logic [7:0] COD_CNT_RST_CH1 = 8'h33;
  localparam logic [7:0] COD_CNT_RST_CH2 = 8'h11;
  localparam logic [7:0] COD_CNT_RST_CH3 = 8'h00;
  localparam logic [7:0] COD_DCTL_RST = 8'h00;
  localparam logic [2:0] COD_OCTL_RST = 3'h0;

  typedef enum logic [1:0] {
    COD_REG_NONE,
    COD_REG_COUNTS,
    COD_REG_DCTL,
    COD_REG_OCTL
  } cod_reg_kind_t;

  typedef struct packed {
    cod_reg_kind_t kind;
    logic [1:0] ch;
  } cod_sel_t;

  typedef struct packed {
    logic [9:0] addr;
    logic [7:0] wdata;
    logic we;
  } cod_reg_req_t;

  typedef struct packed {
    logic c;
    logic b;
    logic a;
  } cod_group_t;

  typedef struct packed {
    logic [2:0][7:0] counts;
    logic [2:0][7:0] dctl;
    logic [2:0][2:0] octl;
    logic [2:0][3:0] cnt;
    logic [2:0][3:0] phase;
    logic [2:0] lvl;
    logic in_phase;
    logic sync_meta;
    logic sync_s;
    logic sync_prev;
    logic osc_meta;
    logic osc_s;
    logic ext_meta;
    logic ext_s;
    logic [7:0] rdata;
    logic [2:0][2:0] out;
  } cod_state_t;

endpackage : cod_pkg

// File: design/cod_channel_divider.sv
`timescale 1ns/10ps
module cod_channel_divider
  import cod_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire cod_reg_req_t reg_req_i,
  output logic [7:0] reg_rdata_o,
  input wire logic sync_i,
  input wire logic osc_clk_i,
  input wire logic ext_clk_i,
  input wire logic [1:0] src_sel_i,
  output cod_group_t group1_output_o,
  output cod_group_t group2_output_o,
  output cod_group_t group3_output_o,
  output logic [2:0] group_pd_o,
  output logic [2:0] duty_cycle_correction_o
);

  cod_state_t q;
  cod_state_t d;

  // address to register kind and channel
  function automatic cod_sel_t cod_decode(input logic [9:0] addr);
    cod_sel_t s;
    s.kind = COD_REG_NONE;
    s.ch = 2'h0;
    if (addr == COD_CH1_COUNTS)
    begin
      s.kind = COD_REG_COUNTS;
      s.ch = 2'h0;
    end
    else if (addr == COD_CH1_DCTL)
    begin
      s.kind = COD_REG_DCTL;
      s.ch = 2'h0;
    end
    else if (addr == COD_CH1_OCTL)
    begin
      s.kind = COD_REG_OCTL;
      s.ch = 2'h0;
    end
    else if (addr == COD_CH2_COUNTS)
    begin
      s.kind = COD_REG_COUNTS;
      s.ch = 2'h1;
    end
    else if (addr == COD_CH2_DCTL)
    begin
      s.kind = COD_REG_DCTL;
      s.ch = 2'h1;
    end
    else if (addr == COD_CH2_OCTL)
    begin
      s.kind = COD_REG_OCTL;
      s.ch = 2'h1;
    end
    else if (addr == COD_CH3_COUNTS)
    begin
      s.kind = COD_REG_COUNTS;
      s.ch = 2'h2;
    end
    else if (addr == COD_CH3_DCTL)
    begin
      s.kind = COD_REG_DCTL;
      s.ch = 2'h2;
    end
    else if (addr == COD_CH3_OCTL)
    begin
      s.kind = COD_REG_OCTL;
      s.ch = 2'h2;
    end
    return s;
  endfunction : cod_decode

  always_comb
  begin
    cod_sel_t wsel;
    cod_sel_t rsel;
    logic sync_rise;
    logic [3:0] lo_cnt;
    logic [3:0] hi_cnt;
    logic byp;
    logic ign;
    logic frc;
    logic start;
    logic pd;
    logic direct;
    logic div_val;
    logic val;
    wsel = cod_decode(reg_req_i.addr);
    rsel = cod_decode(reg_req_i.addr);
    sync_rise = 1'b0;
    lo_cnt = 4'h0;
    hi_cnt = 4'h0;
    byp = 1'b0;
    ign = 1'b0;
    frc = 1'b0;
    start = 1'b0;
    pd = 1'b0;
    direct = 1'b0;
    div_val = 1'b0;
    val = 1'b0;
    d = q;

    // pin synchronisers
    d.sync_meta = sync_i;
    d.sync_s = q.sync_meta;
    d.sync_prev = q.sync_s;
    d.osc_meta = osc_clk_i;
    d.osc_s = q.osc_meta;
    d.ext_meta = ext_clk_i;
    d.ext_s = q.ext_meta;
    sync_rise = q.sync_s & ~q.sync_prev;

    // input clock as seen by a bypassed divider
    d.in_phase = ~q.in_phase;

    for (int i = 0; i < COD_NCH; i++)
    begin
      lo_cnt = q.counts[i][COD_LOW_HI:COD_LOW_LO];
      hi_cnt = q.counts[i][COD_HIGH_HI:COD_HIGH_LO];
      byp = q.dctl[i][COD_BYPASS_BIT];
      ign = q.dctl[i][COD_IGNSYNC_BIT];
      frc = q.dctl[i][COD_FORCE_BIT];
      start = q.dctl[i][COD_START_BIT];
      pd = q.octl[i][COD_PD_BIT];
      direct = q.octl[i][COD_DIRECT_BIT];

      // divider counters
      if (pd || byp)
      begin
        d.cnt[i] = 4'h0;
        d.phase[i] = 4'h0;
        d.lvl[i] = start;
      end
      else if (sync_rise && !ign)
      begin
        d.lvl[i] = start;
        d.cnt[i] = 4'h0;
        d.phase[i] = q.dctl[i][COD_PHASE_HI:COD_PHASE_LO];
      end
      else if (q.phase[i] != 4'h0)
      begin
        d.phase[i] = q.phase[i] - 4'h1;
      end
      else if (q.lvl[i])
      begin
        if (q.cnt[i] == hi_cnt)
        begin
          d.lvl[i] = 1'b0;
          d.cnt[i] = 4'h0;
        end
        else
        begin
          d.cnt[i] = q.cnt[i] + 4'h1;
        end
      end
      else
      begin
        if (q.cnt[i] == lo_cnt)
        begin
          d.lvl[i] = 1'b1;
          d.cnt[i] = 4'h0;
        end
        else
        begin
          d.cnt[i] = q.cnt[i] + 4'h1;
        end
      end

      // divider output level
      if (byp)
      begin
        div_val = q.in_phase;
      end
      else if (ign && frc)
      begin
        div_val = start;
      end
      else
      begin
        div_val = q.lvl[i];
      end

      // output routing
      if (direct && src_sel_i == COD_SRC_OSC)
      begin
        val = q.osc_s;
      end
      else if (direct && src_sel_i == COD_SRC_EXT)
      begin
        val = q.ext_s;
      end
      else
      begin
        val = div_val;
      end
      d.out[i] = pd ? 3'h0 : {3{val}};
    end

    // register writes
    if (reg_req_i.we)
    begin
      case (wsel.kind)
        COD_REG_COUNTS: d.counts[wsel.ch] = reg_req_i.wdata;
        COD_REG_DCTL: d.dctl[wsel.ch] = reg_req_i.wdata;
        COD_REG_OCTL: d.octl[wsel.ch] = reg_req_i.wdata[COD_OCTL_W-1:0];
        default: d.octl = q.octl;
      endcase
    end

    // read-back, unused bits and unmapped addresses read zero
    case (rsel.kind)
      COD_REG_COUNTS: d.rdata = q.counts[rsel.ch];
      COD_REG_DCTL: d.rdata = q.dctl[rsel.ch];
      COD_REG_OCTL: d.rdata = {5'h00, q.octl[rsel.ch]};
      default: d.rdata = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      q <= '0;
      q.counts <= {COD_CNT_RST_CH3, COD_CNT_RST_CH2, COD_CNT_RST_CH1};
      q.dctl <= {COD_DCTL_RST, COD_DCTL_RST, COD_DCTL_RST};
      q.octl <= {COD_OCTL_RST, COD_OCTL_RST, COD_OCTL_RST};
    end
    else
    begin
      q <= d;
    end
  end

  assign reg_rdata_o = q.rdata;
  assign group1_output_o = q.out[0];
  assign group2_output_o = q.out[1];
  assign group3_output_o = q.out[2];
  always_comb
  begin
    for (int i = 0; i < COD_NCH; i++)
    begin
      group_pd_o[i] = q.octl[i][COD_PD_BIT];
      duty_cycle_correction_o[i] = ~q.octl[i][COD_DCCDIS_BIT];
    end
  end

endmodule : cod_channel_divider

// File: verif/cod_chk_assertions.sv
`timescale 1ns/10ps
module cod_chk
  import cod_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire cod_reg_req_t reg_req_i,
  input wire logic sync_i,
  input wire logic ext_clk_i,
  input wire logic [1:0] src_sel_i,
  input wire cod_group_t group1_output_o,
  input wire cod_group_t group2_output_o,
  input wire cod_group_t group3_output_o,
  input wire logic [2:0] group_pd_o,
  input wire logic [2:0] duty_cycle_correction_o
);
  // shadows of channel 2 registers, quiet timer and group 2 run-length tracking
  logic [7:0] cn_q;
  logic [7:0] ct_q;
  logic [2:0] oc_q;
  logic [5:0] qt_q;
  logic [5:0] run_q;
  logic pv_q;
  logic g;
  logic qt;
  logic nm;
  assign g = group2_output_o.a;
  assign qt = qt_q == 6'h3F;
  assign nm = ct_q[7:5] == 3'h0 && oc_q[2:1] == 2'h0 && qt;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);
  always_ff @(posedge core_clk_i)
  begin
    pv_q <= g;
    run_q <= (g != pv_q) ? 6'h0 : run_q + 6'h1;
    if (sys_rst_i || reg_req_i.we || sync_i || $changed(src_sel_i))
      qt_q <= 6'h0;
    else if (!qt)
      qt_q <= qt_q + 6'h1;
    if (sys_rst_i)
    begin
      cn_q <= COD_CNT_RST_CH2;
      ct_q <= COD_DCTL_RST;
      oc_q <= COD_OCTL_RST;
    end
    else if (reg_req_i.we)
    begin
      if (reg_req_i.addr == COD_CH2_COUNTS)
        cn_q <= reg_req_i.wdata;
      if (reg_req_i.addr == COD_CH2_DCTL)
        ct_q <= reg_req_i.wdata;
      if (reg_req_i.addr == COD_CH2_OCTL)
        oc_q <= reg_req_i.wdata[2:0];
    end
  end
  sequence fall_s;
    pv_q && !g;
  endsequence
  sequence rise_s;
    !pv_q && g;
  endsequence
  a_low_run_len: assert property ((nm and rise_s) |-> run_q == {2'h0, cn_q[7:4]})
    else $error("low run length wrong");
  a_high_run_len: assert property ((nm and fall_s) |-> run_q == {2'h0, cn_q[3:0]})
    else $error("high run length wrong");
  a_bypass_toggle: assert property (ct_q[7] && oc_q[2:1] == 2'h0 && qt |-> g != $past(g))
    else $error("bypass not passing input");
  a_force_level: assert property (ct_q[7:5] == 3'h3 && oc_q[2:1] == 2'h0 && qt |-> g == ct_q[4])
    else $error("forced level wrong");
  a_pd_safe_low: assert property (group_pd_o[1] [*3] |-> group2_output_o == 3'h0)
    else $error("powered down group active");
  a_direct_ext: assert property (oc_q[2:1] == 2'h1 && src_sel_i == 2'h0 && qt |->
    g == $past(ext_clk_i, 3))
    else $error("direct route wrong");
  a_dcc_flag: assert property (reg_req_i.we && reg_req_i.addr == COD_CH2_OCTL |=>
    duty_cycle_correction_o[1] == !$past(reg_req_i.wdata[0]))
    else $error("correction flag wrong");
  a_group_same: assert property (group1_output_o == {3{group1_output_o.a}} &&
    group2_output_o == {3{group2_output_o.a}} && group3_output_o == {3{group3_output_o.a}})
    else $error("group outputs differ");
endmodule : cod_chk
bind cod_channel_divider cod_chk u_chk (.core_clk_i, .sys_rst_i, .reg_req_i, .sync_i,
  .ext_clk_i, .src_sel_i, .group1_output_o, .group2_output_o, .group3_output_o,
  .group_pd_o, .duty_cycle_correction_o);

// File: verif/cod_sink.sv
`timescale 1ns/10ps
module cod_sink
(
  input wire logic core_clk_i,
  input wire logic clk_in_i,
  output logic [7:0] period_o
);
  // downstream load: measures rising-edge spacing
  logic [7:0] cnt_q;
  logic prev_q;
  always_ff @(posedge core_clk_i)
  begin
    prev_q <= clk_in_i;
    if (clk_in_i && !prev_q)
    begin
      period_o <= cnt_q + 8'h01;
      cnt_q <= 8'h00;
    end
    else
      cnt_q <= cnt_q + 8'h01;
  end
endmodule : cod_sink

// File: verif/channel_output_divider_config_tb.sv
`timescale 1ns/10ps
module channel_output_divider_config_tb
  import cod_pkg::*;
;
  logic core_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic sync_i = 1'b0;
  logic osc_clk_i = 1'b0;
  logic ext_clk_i = 1'b0;
  logic [1:0] src_sel_i = 2'h0;
  cod_reg_req_t reg_req_i = '0;
  logic [7:0] rd_q;
  cod_group_t g1, g2, g3;
  logic [2:0] pd;
  logic [2:0] dcc;
  logic [7:0] p1, p2, p3;
  int mismatches = 0;
  int total_checks = 0;
  always #10 core_clk_i = ~core_clk_i;
  cod_channel_divider dut (.core_clk_i, .sys_rst_i, .reg_req_i, .reg_rdata_o(rd_q), .sync_i,
    .osc_clk_i, .ext_clk_i, .src_sel_i, .group1_output_o(g1), .group2_output_o(g2),
    .group3_output_o(g3), .group_pd_o(pd), .duty_cycle_correction_o(dcc));
  cod_sink s1 (.core_clk_i, .clk_in_i(g1.a), .period_o(p1));
  cod_sink s2 (.core_clk_i, .clk_in_i(g2.a), .period_o(p2));
  cod_sink s3 (.core_clk_i, .clk_in_i(g3.a), .period_o(p3));
  task cyc(input int n);
    repeat (n) @(negedge core_clk_i);
  endtask : cyc
  task chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task wr(input logic [9:0] a, input logic [7:0] d);
    reg_req_i = '{a, d, 1'b1};
    cyc(1);
    reg_req_i.we = 1'b0;
  endtask : wr
  task rd(input logic [9:0] a, input logic [7:0] e);
    reg_req_i.addr = a;
    cyc(1);
    chk(rd_q, e);
  endtask : rd
  task stop_test;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : stop_test
  // tests take about 500 cycles
  initial
  begin
    #100000;
    mismatches++;
    stop_test;
  end
  initial
  begin
    cyc(12);
    sys_rst_i = 1'b0;
    rd(COD_CH2_COUNTS, 8'h11);
    rd(COD_CH3_COUNTS, 8'h00);
    rd(COD_CH2_DCTL, 8'h00);
    rd(COD_CH2_OCTL, 8'h00);
    rd(10'h1E0, 8'h00);
    chk({5'h0, dcc}, 8'h07);
    cyc(40);
    chk(p3, 8'h02);
    chk(p2, 8'h04);
    chk(p1, 8'h08);
    $display("test reset done");
    wr(COD_CH2_COUNTS, 8'h23);
    cyc(80);
    chk(p2, 8'h07);
    rd(COD_CH2_COUNTS, 8'h23);
    wr(COD_CH2_DCTL, 8'h80);
    cyc(70);
    chk(p2, 8'h02);
    wr(COD_CH2_DCTL, 8'hF0);
    cyc(70);
    chk(p2, 8'h02);
    wr(COD_CH2_DCTL, 8'h70);
    cyc(70);
    chk({5'h0, g2}, 8'h07);
    $display("test divide done");
    wr(COD_CH2_DCTL, 8'h18);
    cyc(40);
    sync_i = 1'b1;
    cyc(4);
    chk({5'h0, g2}, 8'h07);
    cyc(4);
    chk({5'h0, g2}, 8'h07);
    cyc(8);
    chk({5'h0, g2}, 8'h00);
    sync_i = 1'b0;
    $display("test sync done");
    wr(COD_CH2_OCTL, 8'h04);
    cyc(4);
    chk({2'h0, pd, g2}, 8'h10);
    wr(COD_CH2_OCTL, 8'hFB);
    ext_clk_i = 1'b1;
    cyc(70);
    chk({2'h0, dcc, g2}, 8'h2F);
    ext_clk_i = 1'b0;
    cyc(5);
    chk({2'h0, dcc, g2}, 8'h28);
    src_sel_i = 2'h2;
    osc_clk_i = 1'b1;
    cyc(5);
    chk({5'h0, g2}, 8'h07);
    rd(COD_CH2_OCTL, 8'h03);
    $display("test output done");
    stop_test;
  end
endmodule : channel_output_divider_config_tb
